//--- hdl/sfps_top.sv
`timescale 1ns/100ps
`include "sfps_consts.svh"
module sfps_top (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      link_clk,
   input  wire logic                      link_din,
   output logic                           link_dout,
   input  wire logic                      write_protect,
   input  wire logic                      boot_protect,
   output logic                           flash_req,
   output logic                           flash_write,
   output logic [`SFPS_ADDR_W-1:0]        flash_addr,
   output logic [`SFPS_ADDR_W-1:0]        flash_end_addr,
   output logic [7:0]                     flash_wdata,
   input  wire logic                      flash_ack,
   input  wire logic                      flash_err,
   output logic                           busy,
   output logic                           done,
   output sfps_pkg::sfps_outcome_e        outcome
);
   import sfps_pkg::*;

   logic [2:0]                clk_s_r;
   logic [2:0]                din_s_r;
   logic                      clk_lv_r;
   logic [2:0]                bit_cnt_r;
   logic [7:0]                rx_sh_r;
   logic [7:0]                rx_byte_r;
   logic                      rx_v_r;
   logic [7:0]                tx_sh_r;
   logic                      tx_act_r;
   logic [2:0]                tx_idx_r;
   sfps_parse_e               p_st_r;
   logic                      p_cmd_r;
   logic [8:0]                p_len_r;
   logic [8:0]                p_cnt_r;
   logic [7:0]                p_sum_r;
   logic [7:0]                prm_r [0:7];
   logic [7:0]                buf_r [0:255];
   logic                      frm_v_r;
   logic                      frm_etx_r;
   logic                      frm_etb_r;
   sfps_state_e               state_r;
   logic [`SFPS_ADDR_W-1:0]   cur_addr_r;
   logic [8:0]                w_cnt_r;
   logic                      last_r;
   logic                      st_load_r;
   logic                      st_two_r;
   logic [7:0]                st1_r;
   logic [7:0]                st2_r;
   function automatic logic [7:0] status_byte(input logic [2:0] idx, input logic two,
                                              input logic [7:0] s1, input logic [7:0] s2);
      logic [7:0] len;
      logic [7:0] sum;
      len = two ? 8'h02 : 8'h01;
      sum = 8'h00 - len - s1 - (two ? s2 : 8'h00);
      unique case (idx)
         3'h0: status_byte = `SFPS_STX;
         3'h1: status_byte = len;
         3'h2: status_byte = s1;
         3'h3: status_byte = two ? s2 : sum;
         3'h4: status_byte = two ? sum : `SFPS_ETX;
         default: status_byte = `SFPS_ETX;
      endcase
   endfunction
   // Link clock edges, counted once stages two and three agree
   wire clk_agree = (clk_s_r[1] == clk_s_r[2]);
   wire link_rise = clk_agree & clk_s_r[2] & ~clk_lv_r;
   wire link_fall = clk_agree & ~clk_s_r[2] & clk_lv_r;
   wire [2:0] tx_last = st_two_r ? 3'h5 : 3'h4;
   wire [7:0] tx_next = tx_act_r ? status_byte(tx_idx_r, st_two_r, st1_r, st2_r)
                                 : `SFPS_IDLE_BYTE;

   always_ff @(posedge clk) begin
      clk_s_r <= {clk_s_r[1:0], link_clk};
      din_s_r <= {din_s_r[1:0], link_din};
      // Level follows the pin through reset, so release makes no edge
      if (rst || clk_agree) begin
         clk_lv_r <= clk_s_r[2];
      end
   end
   // Bits in on rising edges, out on falling edges, MSB first
   always_ff @(posedge clk) begin
      if (rst) begin
         bit_cnt_r <= 3'h0;
         rx_sh_r   <= 8'h00;
         rx_byte_r <= 8'h00;
         rx_v_r    <= 1'b0;
      end else begin
         rx_v_r <= 1'b0;
         if (link_rise) begin
            rx_sh_r   <= {rx_sh_r[6:0], din_s_r[2]};
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7) begin
               rx_byte_r <= {rx_sh_r[6:0], din_s_r[2]};
               rx_v_r    <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tx_sh_r   <= `SFPS_IDLE_BYTE;
         link_dout <= 1'b1;
         tx_act_r  <= 1'b0;
         tx_idx_r  <= 3'h0;
      end else if (st_load_r) begin
         tx_act_r <= 1'b1;
         tx_idx_r <= 3'h0;
      end else if (link_fall) begin
         if (bit_cnt_r == 3'h0) begin
            tx_sh_r   <= {tx_next[6:0], 1'b1};
            link_dout <= tx_next[7];
            if (tx_act_r) begin
               tx_idx_r <= tx_idx_r + 3'h1;
               tx_act_r <= (tx_idx_r != tx_last);
            end
         end else begin
            tx_sh_r   <= {tx_sh_r[6:0], 1'b1};
            link_dout <= tx_sh_r[7];
         end
      end
   end
   // Frame parser: head, length, body, checksum, end marker
   always_ff @(posedge clk) begin
      if (rst) begin
         p_st_r    <= SFPS_P_HEAD;
         p_cmd_r   <= 1'b0;
         p_len_r   <= 9'h000;
         p_cnt_r   <= 9'h000;
         p_sum_r   <= 8'h00;
         frm_v_r   <= 1'b0;
         frm_etx_r <= 1'b0;
         frm_etb_r <= 1'b0;
      end else begin
         frm_v_r <= 1'b0;
         if (rx_v_r) begin
            unique case (p_st_r)
               SFPS_P_HEAD: begin
                  p_cmd_r <= (rx_byte_r == `SFPS_SOH);
                  p_sum_r <= 8'h00;
                  p_cnt_r <= 9'h000;
                  if (rx_byte_r == `SFPS_SOH || rx_byte_r == `SFPS_STX) begin
                     p_st_r <= SFPS_P_LEN;
                  end
               end
               SFPS_P_LEN: begin
                  p_len_r <= {(rx_byte_r == 8'h00), rx_byte_r};
                  p_sum_r <= p_sum_r + rx_byte_r;
                  p_st_r  <= SFPS_P_BODY;
               end
               SFPS_P_BODY: begin
                  p_sum_r <= p_sum_r + rx_byte_r;
                  p_cnt_r <= p_cnt_r + 9'h001;
                  if (p_cnt_r == p_len_r - 9'h001) begin
                     p_st_r <= SFPS_P_SUM;
                  end
               end
               SFPS_P_SUM: begin
                  p_sum_r <= p_sum_r + rx_byte_r;
                  p_st_r  <= SFPS_P_END;
               end
               SFPS_P_END: begin
                  frm_etx_r <= (rx_byte_r == `SFPS_ETX);
                  frm_etb_r <= (rx_byte_r == `SFPS_ETB);
                  frm_v_r   <= 1'b1;
                  p_st_r    <= SFPS_P_HEAD;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rx_v_r && p_st_r == SFPS_P_BODY) begin
         if (p_cmd_r && p_cnt_r < 9'h008) begin
            prm_r[p_cnt_r[2:0]] <= rx_byte_r;
         end
         if (!p_cmd_r) begin
            buf_r[p_cnt_r[7:0]] <= rx_byte_r;
         end
      end
   end
   // Command checks, malformed first, then checksum, parameters, protection
   wire [`SFPS_ADDR_W-1:0] sa = {prm_r[1], prm_r[2], prm_r[3]};
   wire [`SFPS_ADDR_W-1:0] ea = {prm_r[4], prm_r[5], prm_r[6]};
   wire sum_ok    = (p_sum_r == 8'h00);
   wire cmd_bad   = !frm_etx_r || p_len_r != `SFPS_CMD_LEN || prm_r[0] != `SFPS_CMD_PROG;
   wire addr_ok   = (sa[`SFPS_BLK_BITS-1:0] == '0) && (&ea[`SFPS_BLK_BITS-1:0])
                    && (ea >= sa) && (ea - sa >= `SFPS_MIN_SPAN);
   wire prot_hit  = write_protect || (boot_protect && sa <= `SFPS_BOOT_END);
   wire [7:0] cmd_code = cmd_bad   ? `SFPS_NACK :
                         !sum_ok   ? `SFPS_ERR_SUM :
                         !addr_ok  ? `SFPS_ERR_PARAM :
                         prot_hit  ? `SFPS_ERR_PROT :
                         `SFPS_ACK;
   wire [7:0] dat_code = !(frm_etx_r || frm_etb_r) ? `SFPS_NACK :
                         !sum_ok ? `SFPS_ERR_SUM : `SFPS_ACK;
   wire w_final = flash_err || (w_cnt_r == p_len_r - 9'h001);
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r        <= SFPS_ST_IDLE;
         cur_addr_r     <= '0;
         w_cnt_r        <= 9'h000;
         last_r         <= 1'b0;
         st_load_r      <= 1'b0;
         st_two_r       <= 1'b0;
         st1_r          <= 8'h00;
         st2_r          <= 8'h00;
         flash_req      <= 1'b0;
         flash_write    <= 1'b0;
         flash_addr     <= '0;
         flash_end_addr <= '0;
         flash_wdata    <= 8'h00;
         busy           <= 1'b0;
         done           <= 1'b0;
         outcome        <= SFPS_OUT_NONE;
      end else begin
         done      <= 1'b0;
         st_load_r <= 1'b0;
         unique case (state_r)
            SFPS_ST_IDLE: if (frm_v_r && p_cmd_r) begin
               st_load_r <= 1'b1;
               st_two_r  <= 1'b0;
               st1_r     <= cmd_code;
               if (cmd_code == `SFPS_ACK) begin
                  state_r        <= SFPS_ST_DATA;
                  cur_addr_r     <= sa;
                  flash_end_addr <= ea;
                  busy           <= 1'b1;
                  outcome        <= SFPS_OUT_NONE;
               end else begin
                  done    <= 1'b1;
                  outcome <= SFPS_OUT_B;
               end
            end
            SFPS_ST_DATA: if (frm_v_r && !p_cmd_r) begin
               if (dat_code != `SFPS_ACK) begin
                  st_load_r <= 1'b1;
                  st_two_r  <= 1'b0;
                  st1_r     <= dat_code;
                  state_r   <= SFPS_ST_IDLE;
                  busy      <= 1'b0;
                  done      <= 1'b1;
                  outcome   <= SFPS_OUT_B;
               end else begin
                  w_cnt_r <= 9'h000;
                  last_r  <= frm_etx_r;
                  state_r <= SFPS_ST_WRITE;
               end
            end
            SFPS_ST_WRITE: if (!flash_req) begin
               flash_req   <= 1'b1;
               flash_write <= 1'b1;
               flash_addr  <= cur_addr_r;
               flash_wdata <= buf_r[w_cnt_r[7:0]];
            end else if (flash_ack) begin
               flash_req  <= 1'b0;
               cur_addr_r <= cur_addr_r + 1'b1;
               w_cnt_r    <= w_cnt_r + 9'h001;
               if (w_final) begin
                  st_load_r <= 1'b1;
                  st_two_r  <= 1'b1;
                  st1_r     <= `SFPS_ACK;
                  st2_r     <= flash_err ? `SFPS_ERR_WRITE : `SFPS_ACK;
                  if (flash_err) begin
                     state_r <= SFPS_ST_IDLE;
                     busy    <= 1'b0;
                     done    <= 1'b1;
                     outcome <= SFPS_OUT_D;
                  end else begin
                     state_r <= last_r ? SFPS_ST_VFY : SFPS_ST_DATA;
                  end
               end
            end
            SFPS_ST_VFY: if (!flash_req) begin
               flash_req   <= 1'b1;
               flash_write <= 1'b0;
               flash_addr  <= {sa[`SFPS_ADDR_W-1:`SFPS_BLK_BITS], {`SFPS_BLK_BITS{1'b0}}};
            end else if (flash_ack) begin
               flash_req <= 1'b0;
               st_load_r <= 1'b1;
               st_two_r  <= 1'b0;
               st1_r     <= flash_err ? `SFPS_ERR_VFY : `SFPS_ACK;
               outcome   <= flash_err ? SFPS_OUT_E : SFPS_OUT_A;
               state_r   <= SFPS_ST_IDLE;
               busy      <= 1'b0;
               done      <= 1'b1;
            end
            default: state_r <= SFPS_ST_IDLE;
         endcase
      end
   end
endmodule

//--- hdl/sfps_consts.svh
`ifndef SFPS_CONSTS_SVH
`define SFPS_CONSTS_SVH
`define SFPS_SOH        8'h01
`define SFPS_STX        8'h02
`define SFPS_ETX        8'h03
`define SFPS_ETB        8'h17
`define SFPS_ACK        8'h06
`define SFPS_ERR_PARAM  8'h05
`define SFPS_ERR_SUM    8'h07
`define SFPS_ERR_PROT   8'h10
`define SFPS_NACK       8'h15
`define SFPS_ERR_VFY    8'h1B
`define SFPS_ERR_WRITE  8'h1C
`define SFPS_IDLE_BYTE  8'hFF
// Programming command code, value arbitrary
`define SFPS_CMD_PROG   8'h40
`define SFPS_CMD_LEN    9'h007
`define SFPS_ADDR_W     24
`define SFPS_BLK_BITS   12
// Last byte of the boot block cluster, value arbitrary
`define SFPS_BOOT_END   24'h003FFF
// Two words, minus one
`define SFPS_MIN_SPAN   24'h000007
`endif

//--- hdl/sfps_pkg.sv
package sfps_pkg;
   typedef enum logic [2:0] {SFPS_ST_IDLE, SFPS_ST_DATA, SFPS_ST_WRITE, SFPS_ST_VFY} sfps_state_e;
   typedef enum logic [2:0] {SFPS_P_HEAD, SFPS_P_LEN, SFPS_P_BODY, SFPS_P_SUM,
                             SFPS_P_END} sfps_parse_e;
   typedef enum logic [2:0] {SFPS_OUT_NONE, SFPS_OUT_A, SFPS_OUT_B, SFPS_OUT_D,
                             SFPS_OUT_E} sfps_outcome_e;
endpackage

//--- verif/sfps_chk.sv
`timescale 1ns/100ps
`include "sfps_consts.svh"
module sfps_chk (
   input wire logic                    clk,
   input wire logic                    rst,
   input wire logic                    flash_req,
   input wire logic                    flash_write,
   input wire logic [`SFPS_ADDR_W-1:0] flash_addr,
   input wire logic [7:0]              flash_wdata,
   input wire logic                    flash_ack,
   input wire logic                    flash_err,
   input wire logic                    busy,
   input wire logic                    done,
   input sfps_pkg::sfps_outcome_e      outcome
);
   import sfps_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_ack(w);
      flash_req && flash_ack && flash_write == w;
   endsequence
   a_req_hold: assert property (flash_req && !flash_ack |=>
      flash_req && $stable({flash_write, flash_addr, flash_wdata})) else $error("req changed");
   a_req_release: assert property (flash_req && flash_ack |=> !flash_req)
      else $error("req held after ack");
   a_done_pulse: assert property (done |=> !done) else $error("done too long");
   a_done_idle: assert property (done |=> !busy && !flash_req)
      else $error("busy after end");
   a_done_class: assert property (done |-> outcome != SFPS_OUT_NONE)
      else $error("done without outcome");
   a_outcome_hold: assert property (!$stable(outcome) |-> done || busy)
      else $error("outcome moved while idle");
   a_write_fail: assert property (s_ack(1'b1) ##0 flash_err |-> ##[1:8]
      done && outcome == SFPS_OUT_D) else $error("write failure not D");
   a_write_stop: assert property (s_ack(1'b1) ##0 flash_err |=> !flash_req [*8])
      else $error("write after failure");
   a_vfy_fail: assert property (s_ack(1'b0) ##0 flash_err |-> ##[1:8]
      done && outcome == SFPS_OUT_E) else $error("verify failure not E");
   a_vfy_pass: assert property (s_ack(1'b0) ##0 !flash_err |-> ##[1:8]
      done && outcome == SFPS_OUT_A) else $error("verify pass not A");
endmodule
bind sfps_top sfps_chk i_chk (.clk(clk), .rst(rst), .flash_req(flash_req),
   .flash_write(flash_write), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
   .flash_ack(flash_ack), .flash_err(flash_err), .busy(busy), .done(done), .outcome(outcome));

//--- verif/sfps_prog_model.sv
`timescale 1ns/100ps
module sfps_prog_model #(
   parameter int CMD_GAP_NS = 2000,
   parameter int FRM_GAP_NS = 1000,
   parameter int ST_WAIT_NS = 500
) (
   output logic      link_clk,
   output logic      link_din,
   input  wire logic link_dout
);
   initial {link_clk, link_din} = 2'h3;
   // One byte each way, clock parked high between bytes
   task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         link_clk = 1'b0;
         link_din = tx[i];
         #40 link_clk = 1'b1;
         #39 rx[i] = link_dout;
         #1;
      end
      link_din = ~link_din;
   endtask
   task automatic send_frame(input logic [7:0] head, input logic [7:0] body[$],
                             input logic [7:0] tail, input logic bad_sum);
      logic [7:0] sum, rx;
      sum = 8'(body.size());
      foreach (body[i]) sum += body[i];
      #((head == 8'h01 ? CMD_GAP_NS : FRM_GAP_NS) + 3);
      xbyte(head, rx);
      xbyte(8'(body.size()), rx);
      foreach (body[i]) xbyte(body[i], rx);
      xbyte(-sum ^ {7'h00, bad_sum}, rx);
      xbyte(tail, rx);
   endtask
   task automatic get_status(input int tries, output logic [7:0] st1, st2, output logic got);
      logic [7:0] rx, len, sum;
      st2 = 8'h00;
      rx = 8'hFF;
      #ST_WAIT_NS;
      for (int n = 0; n < tries && rx != 8'h02; n++)
         xbyte(8'hFF, rx);
      xbyte(8'hFF, len);
      xbyte(8'hFF, st1);
      if (len == 8'h02)
         xbyte(8'hFF, st2);
      xbyte(8'hFF, sum);
      sum += len + st1 + st2;
      xbyte(8'hFF, rx);
      got = rx == 8'h03 && sum == 8'h00;
   endtask
endmodule

//--- verif/sfps_tb.sv
`timescale 1ns/100ps
`include "sfps_consts.svh"
module sfps_tb;
   import sfps_pkg::*;
   logic                    clk, rst, link_clk, link_din, link_dout, write_protect, boot_protect;
   logic                    flash_req, flash_write, flash_ack, flash_err, busy, done, vfy_err;
   logic [`SFPS_ADDR_W-1:0] flash_addr, flash_end_addr;
   logic [7:0]              flash_wdata;
   logic [47:0]             vfy_a;
   logic [31:0]             exp_q[$], got_q[$];
   sfps_outcome_e           outcome;
   int                      errors, num_checks, seed, err_at, wr_idx, ndone, wcnt, lim;
   sfps_top i_dut (.clk(clk), .rst(rst), .link_clk(link_clk), .link_din(link_din),
      .link_dout(link_dout), .write_protect(write_protect), .boot_protect(boot_protect),
      .flash_req(flash_req), .flash_write(flash_write), .flash_addr(flash_addr),
      .flash_end_addr(flash_end_addr), .flash_wdata(flash_wdata), .flash_ack(flash_ack),
      .flash_err(flash_err), .busy(busy), .done(done), .outcome(outcome));
   sfps_prog_model i_prog (.link_clk(link_clk), .link_din(link_din), .link_dout(link_dout));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Flash array stand-in, slow on internal verify
   always @(negedge clk) begin
      if (!flash_req || flash_ack) begin
         flash_ack <= 1'b0;
         wcnt      <= 0;
      end else if (wcnt >= (flash_write ? lim : 1000)) begin
         flash_ack <= 1'b1;
         flash_err <= flash_write ? wr_idx == err_at : vfy_err;
         lim       <= $random(seed) & 3;
      end else
         wcnt <= wcnt + 1;
   end
   always @(posedge clk) begin
      if (flash_req && flash_ack && flash_write) begin
         if (!flash_err)
            got_q.push_back({flash_addr, flash_wdata});
         wr_idx <= wr_idx + 1;
      end else if (flash_req && flash_ack)
         vfy_a <= {flash_addr, flash_end_addr};
      if (done === 1'b1)
         ndone <= ndone + 1;
   end
   task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic prog(input logic [23:0] sa, ea, input logic [7:0] code, es,
                       input logic cbad, input int n, e_at, input logic [1:0] dbad,
                       input logic ve);
      logic [7:0]    b[$];
      logic [7:0]    s1, s2;
      logic [23:0]   a;
      logic          got, err;
      int            k, w, d0, vt;
      sfps_outcome_e eo;
      b = {code, sa[23:16], sa[15:8], sa[7:0], ea[23:16], ea[15:8], ea[7:0]};
      exp_q.delete();
      got_q.delete();
      wr_idx = 0;
      w = 0;
      err_at = e_at;
      vfy_err = ve;
      d0 = ndone;
      a = sa;
      err = 1'b0;
      i_prog.send_frame(8'h01, b, 8'h03, cbad);
      i_prog.get_status(64, s1, s2, got);
      chk("cmd_frame", 1, got);
      chk("cmd_status", es, s1);
      chk("busy_run", es == 8'h06, busy);
      eo = es == 8'h06 ? SFPS_OUT_A : SFPS_OUT_B;
      while (eo == SFPS_OUT_A && n > 0) begin
         k = n > 256 ? 256 : n;
         n -= k;
         b.delete();
         repeat (k) begin
            b.push_back(8'($random(seed)));
            if (!dbad && !err && w == e_at)
               err = 1'b1;
            else if (!dbad && !err)
               exp_q.push_back({a, b[$]});
            w++;
            a++;
         end
         i_prog.send_frame(8'h02, b, dbad[1] ? 8'h04 : n == 0 ? 8'h03 : 8'h17, dbad[0]);
         i_prog.get_status(64, s1, s2, got);
         chk("data_frame", 1, got);
         chk("data_rx_status", dbad[1] ? 8'h15 : dbad[0] ? 8'h07 : 8'h06, s1);
         if (!dbad) chk("data_wr_status", err ? 8'h1C : 8'h06, s2);
         eo = dbad ? SFPS_OUT_B : err ? SFPS_OUT_D : SFPS_OUT_A;
      end
      if (eo == SFPS_OUT_A) begin
         vt = 16 + 16 * (((ea - sa) >> `SFPS_BLK_BITS) + 1);
         i_prog.get_status(vt, s1, s2, got);
         chk("vfy_frame", 1, got);
         chk("vfy_status", ve ? 8'h1B : 8'h06, s1);
         chk("vfy_range", {sa, ea}, vfy_a);
         eo = ve ? SFPS_OUT_E : SFPS_OUT_A;
      end
      chk("done_count", d0 + 1, ndone);
      chk("busy_end", 0, busy);
      chk("outcome", eo, outcome);
      chk("writes", exp_q.size(), got_q.size());
      foreach (exp_q[i]) chk("write", exp_q[i], got_q[i]);
      $display("test end outcome %s", eo.name());
   endtask
   initial begin
      static logic [55:0] tc[6] = '{{8'h41, 24'h010000, 24'h010FFF},
         {8'h40, 24'h010800, 24'h010FFF},
         {8'h40, 24'h010800, 24'h010FFF}, {8'h40, 24'h010000, 24'h010FFE},
         {8'h40, 24'h010000, 24'h010FFF}, {8'h40, 24'h003000, 24'h003FFF}};
      static logic [7:0] et[6] = '{8'h15, 8'h07, 8'h05, 8'h05, 8'h10, 8'h10};
      {rst, write_protect, boot_protect, flash_ack, flash_err, vfy_err} = 6'h20;
      seed = 50509;
      err_at = -1;
      repeat (16) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      repeat (4) @(negedge clk);
      for (int i = 0; i < 6; i++) begin
         @(negedge clk) {write_protect, boot_protect} = {i == 2 || i == 4, i == 5};
         prog(tc[i][47:24], tc[i][23:0], tc[i][55:48], et[i], i < 2, 8, -1, 0, 0);
      end
      @(negedge clk) {write_protect, boot_protect} = 2'h1;
      prog(24'h004000, 24'h004FFF, `SFPS_CMD_PROG, 8'h06, 0, 259, -1, 0, 0);
      prog(24'h020000, 24'h021FFF, `SFPS_CMD_PROG, 8'h06, 0, 20, 13, 0, 0);
      prog(24'h030000, 24'h030FFF, `SFPS_CMD_PROG, 8'h06, 0, 8, -1, 0, 1);
      prog(24'h030000, 24'h030FFF, `SFPS_CMD_PROG, 8'h06, 0, 8, -1, 1, 0);
      prog(24'h030000, 24'h030FFF, `SFPS_CMD_PROG, 8'h06, 0, 8, -1, 2, 0);
      tally_and_finish();
   end
   initial begin
      #750000;
      errors++;
      tally_and_finish();
   end
endmodule
